// [logic/eeprom_read_pkg.sv]
// constants and carrier types for the serial memory read sequencer
// assumes a single 25 MHz core clock and a two-wire bus sampled from pins
package eeprom_read_pkg;

    // memory geometry
    localparam int unsigned ADDR_WIDTH = 16;
    localparam int unsigned DATA_WIDTH = 8;

    // fixed class code in the upper nibble of the target address
    localparam logic [3:0] CLASS_CODE = 4'ha;

    // last bit index within a byte
    localparam logic [2:0] LAST_BIT = 3'h7;

    // read-back buffer
    localparam logic [1:0] BUF_DEPTH = 2'h2;

    // address reset value and the byte sent from an empty buffer
    localparam logic [ADDR_WIDTH-1:0] ADDR_RESET = 16'h0000;
    localparam logic [DATA_WIDTH-1:0] EMPTY_BYTE = 8'hff;

    // sequencer states
    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_addr_ack,
        st_waddr,
        st_waddr_ack,
        st_tx,
        st_tx_ack,
        st_ignore
    } seq_state_e;

    // memory read request, one-cycle valid
    typedef struct packed {
        logic                  valid;
        logic [ADDR_WIDTH-1:0] addr;
    } mem_req_s;

    // memory read answer
    typedef struct packed {
        logic                  valid;
        logic [DATA_WIDTH-1:0] data;
    } mem_rsp_s;

endpackage

// [logic/i2c_eeprom_read_sequencer.sv]
// read-side sequencer of a two-wire serial memory target
// assumes the bus pins are asynchronous and the memory array answers
// a read request within 6 core clocks, on the core clock
`timescale 1ns/1ns
module i2c_eeprom_read_sequencer (
    // core clock and reset
    input  wire logic                       clock,
    input  wire logic                       reset,
    // two-wire bus pins
    input  wire logic                       scl_in,
    input  wire logic                       sda_in,
    output wire logic                       sda_out,
    output logic                            sda_oe_n,
    // device select straps
    input  wire logic                       device_select_bit0,
    input  wire logic                       device_select_bit1,
    input  wire logic                       device_select_bit2,
    // write engine status
    input  wire logic                       write_busy,
    // memory array read port
    output eeprom_read_pkg::mem_req_s       mem_req,
    input  eeprom_read_pkg::mem_rsp_s       mem_rsp,
    output logic                            mem_rsp_ready
);

    // pin synchronisers and edge history
    logic       scl_meta, scl_sync, scl_prev;
    logic       sda_meta, sda_sync, sda_prev;
    logic [2:0] sel_meta, sel_sync;
    logic       scl_rise, scl_fall, bus_start, bus_stop;

    // sequencer state
    eeprom_read_pkg::seq_state_e                  state, next_state;
    logic [eeprom_read_pkg::DATA_WIDTH-1:0]       shreg, next_shreg;
    logic [eeprom_read_pkg::DATA_WIDTH-1:0]       addr_hi, next_addr_hi;
    logic [eeprom_read_pkg::ADDR_WIDTH-1:0]       addr_cnt, next_addr_cnt;
    logic [2:0]                                   bit_cnt, next_bit_cnt;
    logic                                         byte_full, next_byte_full;
    logic                                         addr_idx, next_addr_idx;
    logic                                         acked, next_acked;
    logic                                         next_sda_oe_n;
    eeprom_read_pkg::mem_req_s                    next_mem_req;
    logic                                         pop, flush;

    // two-entry read-back buffer
    logic [eeprom_read_pkg::DATA_WIDTH-1:0] buf_mem [2];
    logic [eeprom_read_pkg::DATA_WIDTH-1:0] next_buf_mem [2];
    logic                                   wr_ptr, next_wr_ptr;
    logic                                   rd_ptr, next_rd_ptr;
    logic [1:0]                             buf_cnt, next_buf_cnt;
    logic                                   next_rsp_ready;
    logic                                   push;
    logic [eeprom_read_pkg::DATA_WIDTH-1:0] head;

    // open drain: the pin is only ever pulled low
    assign sda_out = 1'b0;

    // two-flop synchronisers, then one history stage for edges
    always_ff @(posedge clock) begin
        if (reset) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_prev <= 1'b1;
            sel_meta <= 3'h0;
            sel_sync <= 3'h0;
        end else begin
            scl_meta <= scl_in;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
            sda_prev <= sda_sync;
            sel_meta <= {device_select_bit2, device_select_bit1, device_select_bit0};
            sel_sync <= sel_meta;
        end
    end

    // bus events from synchronised levels
    assign scl_rise  = scl_sync & ~scl_prev;
    assign scl_fall  = ~scl_sync & scl_prev;
    assign bus_start = scl_sync & scl_prev & sda_prev & ~sda_sync;
    assign bus_stop  = scl_sync & scl_prev & ~sda_prev & sda_sync;
    assign head      = (buf_cnt != 2'h0) ? buf_mem[rd_ptr] : eeprom_read_pkg::EMPTY_BYTE;

    // sequencer next state
    always_comb begin
        next_state     = state;
        next_shreg     = shreg;
        next_addr_hi   = addr_hi;
        next_addr_cnt  = addr_cnt;
        next_bit_cnt   = bit_cnt;
        next_byte_full = byte_full;
        next_addr_idx  = addr_idx;
        next_acked     = acked;
        next_sda_oe_n  = sda_oe_n;
        next_mem_req   = '0;
        pop            = 1'b0;
        flush          = 1'b0;
        if (bus_stop) begin
            next_state    = eeprom_read_pkg::st_idle;
            next_sda_oe_n = 1'b1;
            flush         = 1'b1;
        end else if (bus_start) begin
            next_state     = eeprom_read_pkg::st_addr;
            next_bit_cnt   = 3'h0;
            next_byte_full = 1'b0;
            next_sda_oe_n  = 1'b1;
            flush          = 1'b1;
        end else begin
            case (state)
                // shift in a target address or memory address byte
                eeprom_read_pkg::st_addr, eeprom_read_pkg::st_waddr: begin
                    if (scl_rise && !byte_full) begin
                        next_shreg   = {shreg[6:0], sda_sync};
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (bit_cnt == eeprom_read_pkg::LAST_BIT) begin
                            next_byte_full = 1'b1;
                        end
                    end else if (scl_fall && byte_full) begin
                        next_byte_full = 1'b0;
                        if (state == eeprom_read_pkg::st_waddr) begin
                            next_sda_oe_n = 1'b0;
                            next_state    = eeprom_read_pkg::st_waddr_ack;
                        end else if (shreg[7:4] == eeprom_read_pkg::CLASS_CODE &&
                                     shreg[3:1] == sel_sync && !write_busy) begin
                            next_sda_oe_n = 1'b0;
                            next_state    = eeprom_read_pkg::st_addr_ack;
                            if (shreg[0]) begin
                                next_mem_req.valid = 1'b1;
                                next_mem_req.addr  = addr_cnt;
                            end
                        end else begin
                            next_state = eeprom_read_pkg::st_ignore;
                        end
                    end
                end
                // end of the address acknowledge clock
                eeprom_read_pkg::st_addr_ack: begin
                    if (scl_fall) begin
                        next_bit_cnt = 3'h0;
                        if (shreg[0]) begin
                            pop           = 1'b1;
                            next_shreg    = head;
                            next_sda_oe_n = head[7];
                            next_state    = eeprom_read_pkg::st_tx;
                        end else begin
                            next_sda_oe_n = 1'b1;
                            next_addr_idx = 1'b0;
                            next_state    = eeprom_read_pkg::st_waddr;
                        end
                    end
                end
                // end of a memory address acknowledge
                eeprom_read_pkg::st_waddr_ack: begin
                    if (scl_fall) begin
                        next_sda_oe_n = 1'b1;
                        next_bit_cnt  = 3'h0;
                        if (!addr_idx) begin
                            next_addr_hi  = shreg;
                            next_addr_idx = 1'b1;
                            next_state    = eeprom_read_pkg::st_waddr;
                        end else begin
                            next_addr_cnt = {addr_hi, shreg};
                            next_state    = eeprom_read_pkg::st_ignore;
                        end
                    end
                end
                // shift a byte out on falling edges
                eeprom_read_pkg::st_tx: begin
                    if (scl_fall) begin
                        if (bit_cnt == eeprom_read_pkg::LAST_BIT) begin
                            next_sda_oe_n      = 1'b1;
                            next_addr_cnt      = addr_cnt + 16'h0001;
                            next_mem_req.valid = 1'b1;
                            next_mem_req.addr  = addr_cnt + 16'h0001;
                            next_state         = eeprom_read_pkg::st_tx_ack;
                        end else begin
                            next_bit_cnt  = bit_cnt + 3'h1;
                            next_shreg    = {shreg[6:0], 1'b0};
                            next_sda_oe_n = shreg[6];
                        end
                    end
                end
                // sample the controller's answer in clock nine
                eeprom_read_pkg::st_tx_ack: begin
                    if (scl_rise) begin
                        next_acked = ~sda_sync;
                    end else if (scl_fall) begin
                        pop          = 1'b1;
                        next_bit_cnt = 3'h0;
                        if (acked) begin
                            next_shreg    = head;
                            next_sda_oe_n = head[7];
                            next_state    = eeprom_read_pkg::st_tx;
                        end else begin
                            next_sda_oe_n = 1'b1;
                            next_state    = eeprom_read_pkg::st_ignore;
                        end
                    end
                end
                eeprom_read_pkg::st_idle, eeprom_read_pkg::st_ignore: begin
                    next_sda_oe_n = 1'b1;
                end
                default: begin
                    next_state    = eeprom_read_pkg::st_idle;
                    next_sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    // sequencer registers
    always_ff @(posedge clock) begin
        if (reset) begin
            state     <= eeprom_read_pkg::st_idle;
            shreg     <= 8'h00;
            addr_hi   <= 8'h00;
            addr_cnt  <= eeprom_read_pkg::ADDR_RESET;
            bit_cnt   <= 3'h0;
            byte_full <= 1'b0;
            addr_idx  <= 1'b0;
            acked     <= 1'b0;
            sda_oe_n  <= 1'b1;
            mem_req   <= '0;
        end else begin
            state     <= next_state;
            shreg     <= next_shreg;
            addr_hi   <= next_addr_hi;
            addr_cnt  <= next_addr_cnt;
            bit_cnt   <= next_bit_cnt;
            byte_full <= next_byte_full;
            addr_idx  <= next_addr_idx;
            acked     <= next_acked;
            sda_oe_n  <= next_sda_oe_n;
            mem_req   <= next_mem_req;
        end
    end

    // buffer next state: push from memory, pop by the shifter
    always_comb begin
        push         = mem_rsp.valid & mem_rsp_ready;
        next_buf_mem = buf_mem;
        next_wr_ptr  = wr_ptr;
        next_rd_ptr  = rd_ptr;
        next_buf_cnt = buf_cnt;
        if (flush) begin
            next_buf_cnt = 2'h0;
            next_rd_ptr  = wr_ptr;
        end else begin
            if (push) begin
                next_buf_mem[wr_ptr] = mem_rsp.data;
                next_wr_ptr          = ~wr_ptr;
            end
            if (pop && buf_cnt != 2'h0) begin
                next_rd_ptr = ~rd_ptr;
            end
            next_buf_cnt = buf_cnt + {1'b0, push} - {1'b0, pop && buf_cnt != 2'h0};
        end
        next_rsp_ready = next_buf_cnt < eeprom_read_pkg::BUF_DEPTH;
    end

    // buffer registers
    always_ff @(posedge clock) begin
        if (reset) begin
            buf_mem[0]    <= 8'h00;
            buf_mem[1]    <= 8'h00;
            wr_ptr        <= 1'b0;
            rd_ptr        <= 1'b0;
            buf_cnt       <= 2'h0;
            mem_rsp_ready <= 1'b1;
        end else begin
            buf_mem       <= next_buf_mem;
            wr_ptr        <= next_wr_ptr;
            rd_ptr        <= next_rd_ptr;
            buf_cnt       <= next_buf_cnt;
            mem_rsp_ready <= next_rsp_ready;
        end
    end

endmodule // i2c_eeprom_read_sequencer

// [verif/eeprom_read_assertions.sv]
// concurrent checks on the serial memory read sequencer ports
// assumes one core clock domain and a synchronous active-high reset
`timescale 1ns/1ns
module eeprom_read_assertions (
    // clock and reset
    input wire logic                 clock,
    input wire logic                 reset,
    // bus pins
    input wire logic                 scl_in,
    input wire logic                 sda_in,
    input wire logic                 sda_oe_n,
    // write status and memory request
    input wire logic                 write_busy,
    input eeprom_read_pkg::mem_req_s mem_req,
    input wire logic                 mem_rsp_ready
);
    logic [15:0] last_addr;
    logic [5:0]  busy_cnt;
    logic        scl_q;
    logic        sda_q;
    wire         stop_seen = scl_in && scl_q && sda_in && !sda_q;

    // pin history, last request address, busy run length
    always_ff @(posedge clock) begin
        scl_q <= scl_in;
        sda_q <= sda_in;
        if (mem_req.valid) last_addr <= mem_req.addr;
        busy_cnt <= write_busy ? busy_cnt + {5'h00, busy_cnt != 6'h3f} : 6'h00;
    end

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // address acknowledge and byte continuation requests
    sequence s_addr_ack; mem_req.valid && !sda_oe_n; endsequence
    sequence s_next_req; mem_req.valid && sda_oe_n; endsequence

    property p_reset_idle;
        $fell(reset) |-> sda_oe_n && !mem_req.valid && mem_rsp_ready;
    endproperty
    property p_ack_held; s_addr_ack |-> (!sda_oe_n)[*6]; endproperty
    property p_release_ninth; s_next_req |-> sda_oe_n[*6]; endproperty
    property p_next_addr; s_next_req |-> mem_req.addr == last_addr + 16'h0001; endproperty
    property p_oe_low_phase; $fell(sda_oe_n) |-> !$past(scl_in, 3); endproperty
    property p_stable_high; scl_in && scl_q |-> $stable(sda_oe_n); endproperty
    property p_busy_nack; busy_cnt >= 6'h28 |-> sda_oe_n; endproperty
    property p_stop_idle; stop_seen |=> (sda_oe_n && !mem_req.valid)[*8]; endproperty

    a_reset_idle: assert property (p_reset_idle) else $error("drive after reset");
    a_ack_held: assert property (p_ack_held) else $error("ack not held");
    a_release_ninth: assert property (p_release_ninth) else $error("ninth not released");
    a_next_addr: assert property (p_next_addr) else $error("counter not advanced");
    a_oe_low_phase: assert property (p_oe_low_phase) else $error("drive while clock high");
    a_stable_high: assert property (p_stable_high) else $error("data moved in high");
    a_busy_nack: assert property (p_busy_nack) else $error("ack while busy");
    a_stop_idle: assert property (p_stop_idle) else $error("active after stop");
endmodule // eeprom_read_assertions

bind i2c_eeprom_read_sequencer eeprom_read_assertions chk (
    .clock(clock), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_oe_n(sda_oe_n),
    .write_busy(write_busy), .mem_req(mem_req), .mem_rsp_ready(mem_rsp_ready));

// [verif/i2c_bus_controller.sv]
// behavioural two-wire bus controller that frames reads for the bench
// assumes a pull-up on the data wire and an 8-clock bus period
`timescale 1ns/1ns
module i2c_bus_controller (
    // core clock
    input wire logic  clock,
    // bus lines
    output logic      scl,
    output logic      sda_drv,
    input wire logic  sda_wire,
    // received byte and its strobe
    output logic      got,
    output logic [7:0] rx
);
    // bus idles released with the clock standing high
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        got = 1'b0;
        rx = 8'h00;
    end

    // one bit: 6 clocks low, 2 high, sampled at the end of the high half
    task automatic clk_bit(input logic b, output logic r);
        sda_drv <= b;
        @(posedge clock);
        got <= 1'b0;
        repeat (4) @(posedge clock);
        scl <= 1'b1;
        repeat (2) @(posedge clock);
        r = sda_wire;
        scl <= 1'b0;
        @(posedge clock);
    endtask

    // start, also used as repeated start between address and read
    task automatic start();
        sda_drv <= 1'b1;
        repeat (6) @(posedge clock);
        scl <= 1'b1;
        repeat (4) @(posedge clock);
        sda_drv <= 1'b0;
        repeat (4) @(posedge clock);
        scl <= 1'b0;
        @(posedge clock);
    endtask

    // stop ends every frame
    task automatic stop();
        sda_drv <= 1'b0;
        repeat (4) @(posedge clock);
        scl <= 1'b1;
        repeat (4) @(posedge clock);
        sda_drv <= 1'b1;
        repeat (8) @(posedge clock);
    endtask

    // byte out msb first, then the target's answer
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
        clk_bit(1'b1, ack);
    endtask

    // byte in, then ack or a final nack
    task automatic recv(input logic nack);
        logic [7:0] d;
        logic       r;
        for (int i = 0; i < 8; i++) begin
            clk_bit(1'b1, r);
            d = {d[6:0], r};
        end
        rx <= d;
        got <= 1'b1;
        clk_bit(nack, r);
    endtask
endmodule // i2c_bus_controller

// [verif/tb.sv]
// self-checking bench for the serial memory read sequencer
// assumes the bound checker and the bus controller model
`timescale 1ns/1ns
module tb;
    logic                      clock, reset, scl, sda_drv, sda_wire, got, write_busy;
    logic                      sda_out, sda_oe_n, mem_rsp_ready;
    logic [2:0]                sel;
    logic [7:0]                rx;
    logic [15:0]               addr;
    eeprom_read_pkg::mem_req_s mem_req;
    eeprom_read_pkg::mem_rsp_s mem_rsp;
    logic [7:0]                exp_q[$];
    int                        num_errors, samples_checked, cycles, seed;

    // open-drain wire with pull-up
    assign sda_wire = sda_drv & (sda_oe_n | sda_out);

    i2c_bus_controller ctl (.clock(clock), .scl(scl), .sda_drv(sda_drv), .sda_wire(sda_wire),
        .got(got), .rx(rx));
    i2c_eeprom_read_sequencer dut (.clock(clock), .reset(reset), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .device_select_bit0(sel[0]), .device_select_bit1(sel[1]),
        .device_select_bit2(sel[2]), .write_busy(write_busy), .mem_req(mem_req),
        .mem_rsp(mem_rsp), .mem_rsp_ready(mem_rsp_ready));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    function automatic logic [7:0] exp_byte(input logic [15:0] a);
        // sum with a rotated high byte: 0xffff and 0x0000 give different bytes
        return a[7:0] + {a[14:8], a[15]} + 8'h3c;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        samples_checked++;
        if (seen !== want) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // memory stand-in: answers 1..5 clocks late, holds until taken
    initial begin
        logic [15:0] a;
        mem_rsp <= '0;
        forever begin
            @(posedge clock);
            if (mem_req.valid) begin
                a = mem_req.addr;
                repeat ($unsigned($random(seed)) % 5) @(posedge clock);
                mem_rsp <= {1'b1, exp_byte(a)};
                @(posedge clock);
                while (!mem_rsp_ready) @(posedge clock);
                mem_rsp <= '0;
            end
        end
    end

    // each received byte is matched with the oldest note
    always @(posedge clock) if (got) check(rx, exp_q.pop_front());

    // current-address read of n bytes, last one refused
    task automatic cur_read(input logic [15:0] a, input int n);
        logic ack;
        ctl.start();
        ctl.send({4'ha, sel, 1'b1}, ack);
        check({7'h00, ack}, 8'h00);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(exp_byte(a + i[15:0]));
            ctl.recv(i == n - 1);
        end
        ctl.stop();
        addr = a + n[15:0];
    endtask

    // dummy write of the address, then repeated start and read
    task automatic read_at(input logic [15:0] a, input int n);
        logic ack;
        ctl.start();
        ctl.send({4'ha, sel, 1'b0}, ack);
        check({7'h00, ack}, 8'h00);
        ctl.send(a[15:8], ack);
        check({7'h00, ack}, 8'h00);
        ctl.send(a[7:0], ack);
        check({7'h00, ack}, 8'h00);
        cur_read(a, n);
    endtask

    task automatic expect_nack(input logic [7:0] t);
        logic ack;
        ctl.start();
        ctl.send(t, ack);
        check({7'h00, ack}, 8'h01);
        ctl.stop();
    endtask

    initial begin
        seed = 78;
        reset <= 1'b1;
        write_busy <= 1'b0;
        sel <= 3'h5;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        repeat (4) @(posedge clock);
        // loaded read across the top of memory, then from the counter
        read_at(16'hfffe, 3);
        cur_read(addr, 2);
        $display("wrap test done");
        // foreign class, foreign straps, busy write engine
        expect_nack({4'h5, sel, 1'b1});
        expect_nack({4'ha, ~sel, 1'b1});
        write_busy <= 1'b1;
        expect_nack({4'ha, sel, 1'b1});
        write_busy <= 1'b0;
        cur_read(addr, 1);
        $display("refusal test done");
        // random straps, start addresses and lengths
        for (int k = 0; k < 4; k++) begin
            sel <= 3'($random(seed));
            repeat (4) @(posedge clock);
            read_at(16'($random(seed)), 1 + ($unsigned($random(seed)) % 4));
        end
        $display("random test done");
        conclude();
    end

    // cycle ceiling against hangs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end
endmodule // tb
